// ==== rtl/processor_error_pkg.sv ====
// Shared constants, field positions and carrier types of the processor error capture block.
`default_nettype none
package processor_error_pkg;
   // ---------------------------------------------------------------------------
   // Word layout; bit 0 is the most significant bit of a word
   // ---------------------------------------------------------------------------
   localparam int WORD_W = 36;
   typedef logic [0:WORD_W-1] word_type;
   typedef logic [0:7] flag_type;
   // Command word bits for the processor flag unit.
   localparam int CO_IO_RESET = 19;
   localparam int CO_ENABLE = 20;
   localparam int CO_DISABLE = 21;
   localparam int CO_CLEAR = 22;
   localparam int CO_SET = 23;
   localparam int FLAG_FIRST = 24;
   localparam int FLAG_LAST = 31;
   localparam int IRQ_BIT = 32;
   localparam int LVL_FIRST = 33;
   localparam int LVL_LAST = 35;
   localparam int EN_FIRST = 6;
   localparam int EN_LAST = 13;
   localparam int SWEEP_BUSY_BIT = 19;
   // Index of each flag within flag_type.
   localparam int F_SBUS = 0;
   localparam int F_NOMEM = 1;
   localparam int F_IOPF = 2;
   localparam int F_MBPAR = 3;
   localparam int F_CDIR = 4;
   localparam int F_APAR = 5;
   localparam int F_PWR = 6;
   localparam int F_SWEEP = 7;
   localparam flag_type LOCK_MASK = 8'h54;
   localparam flag_type FLAGS_RST = 8'h00;
   // Priority interrupt command bits that force bad parity.
   localparam int FP_FIRST = 18;
   localparam int FP_LAST = 20;
   // Capture register fields.
   localparam int CAP_WORD_FIRST = 0;
   localparam int CAP_WORD_LAST = 1;
   localparam int CAP_SWEEP = 2;
   localparam int CAP_CHAN = 3;
   localparam int CAP_SRC_FIRST = 4;
   localparam int CAP_SRC_LAST = 5;
   localparam int CAP_WRITE = 6;
   localparam int CAP_ADDR_FIRST = 14;
   localparam int CAP_ADDR_LAST = 35;
   // Data source codes, read side (write bit 0) and write side (write bit 1).
   localparam logic [1:0] SRC_STORAGE = 2'h0;
   localparam logic [1:0] SRC_CACHE_READ = 2'h3;
   localparam logic [1:0] SRC_CHAN_STATUS = 2'h0;
   localparam logic [1:0] SRC_CHAN_DATA = 2'h1;
   localparam logic [1:0] SRC_ARITH = 2'h2;
   localparam logic [1:0] SRC_WRITEBACK = 2'h3;
   // Diagnostic function word fields.
   localparam int DG_SEL_FIRST = 0;
   localparam int DG_SEL_LAST = 4;
   localparam int DG_FUNC_FIRST = 31;
   localparam int DG_FUNC_LAST = 35;
   // ---------------------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------------------
   localparam int CLK_MHZ = 40;
   localparam int NOMEM_TIMEOUT_US = 68;
   localparam int NOMEM_CYCLES = NOMEM_TIMEOUT_US * CLK_MHZ;
   localparam logic [2:0] LEVEL_NONE = 3'h0;
   // ---------------------------------------------------------------------------
   // Carriers and states
   // ---------------------------------------------------------------------------
   typedef enum logic [5:0]
   {
      CMD_NONE = 6'h00,
      CMD_COND_OUT = 6'h01,
      CMD_COND_IN = 6'h02,
      CMD_PI_OUT = 6'h04,
      CMD_PI_IN = 6'h08,
      CMD_READ_CAPTURE = 6'h10,
      CMD_DIAG = 6'h20
   } cmd_op_type;
   typedef struct packed
   {
      cmd_op_type op;
      word_type data;
   } cmd_type;
   typedef struct packed
   {
      logic [1:0] word_num;
      logic sweep;
      logic channel;
      logic [1:0] source;
      logic write;
      logic [21:0] addr;
   } ref_info_type;
   typedef struct packed
   {
      logic addr;
      logic arith;
      logic cache_dir;
   } force_par_type;
   typedef enum logic [2:0]
   {
      DG_IDLE = 3'h1,
      DG_SEND = 3'h2,
      DG_WAIT = 3'h4
   } diag_state_type;
endpackage : processor_error_pkg
`default_nettype wire

// ==== rtl/storage_bus_diag.sv ====
// Storage bus diagnostic cycle sequencer.
`default_nettype none
module storage_bus_diag
#(
   parameter int TIMEOUT_CYC = processor_error_pkg::NOMEM_CYCLES
)
(
   input wire logic clk_sys, // System clock.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic start, // One-cycle request to run a cycle.
   input wire processor_error_pkg::word_type func_word, // Function word to send.
   output logic busy_ff, // Cycle in progress.
   output logic done_ff, // One-cycle pulse, return word valid.
   output processor_error_pkg::word_type ret_ff, // Word returned by the controller.
   output logic diag_req_ff, // Diagnostic cycle request on the storage bus.
   output logic [4:0] diag_sel_ff, // Selected controller number.
   output processor_error_pkg::word_type diag_word_ff, // Function word on the bus.
   input wire logic diag_ack, // Controller took the function word.
   input wire logic diag_ret_valid, // Controller presents its return word.
   input wire processor_error_pkg::word_type diag_ret // Return word.
);
   import processor_error_pkg::*;

   localparam int TW = $clog2(TIMEOUT_CYC + 1);
   if (TIMEOUT_CYC < 2)
   begin : g_chk
      $error("storage_bus_diag timeout too short");
   end

   diag_state_type state_ff;
   diag_state_type nxt_state;
   logic [TW-1:0] tmo_ff;
   wire tmo_hit = (tmo_ff == TW'(TIMEOUT_CYC));
   wire finish = (state_ff == DG_WAIT) && (diag_ret_valid || tmo_hit);

   // A controller that never answers would hang the processor, so a timeout
   // completes the cycle with an all-zero return word.
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         DG_IDLE: if (start) nxt_state = DG_SEND;
         DG_SEND: if (diag_ack || tmo_hit) nxt_state = DG_WAIT;
         DG_WAIT: if (finish) nxt_state = DG_IDLE;
         default: nxt_state = DG_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state_ff <= DG_IDLE;
         tmo_ff <= '0;
         done_ff <= 1'b0;
         ret_ff <= '0;
         diag_req_ff <= 1'b0;
         diag_sel_ff <= '0;
         diag_word_ff <= '0;
         busy_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         tmo_ff <= (nxt_state != state_ff) ? '0 : tmo_ff + TW'(1);
         done_ff <= finish;
         busy_ff <= (nxt_state != DG_IDLE);
         diag_req_ff <= (nxt_state == DG_SEND);
         if (finish)
            ret_ff <= diag_ret_valid ? diag_ret : '0;
         if (start && state_ff == DG_IDLE)
         begin
            diag_sel_ff <= func_word[DG_SEL_FIRST:DG_SEL_LAST];
            diag_word_ff <= func_word;
         end
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   diag_start_a: assert property (start && !busy_ff |=> diag_req_ff && busy_ff)
      else $error("diagnostic cycle did not start");
   diag_sel_a: assert property (start && !busy_ff
      |=> diag_sel_ff == $past(func_word[DG_SEL_FIRST:DG_SEL_LAST]))
      else $error("diagnostic controller select wrong");
endmodule : storage_bus_diag
`default_nettype wire

// ==== rtl/processor_error_capture.sv ====
// Processor error flags, interrupt request, error address capture and parity forcing.
//
// Functional notes
// - Memory buffer bad parity sets flag, locks capture.
// - Directory bad parity sets flag, disables cache.
// - Controller address parity error sets flag, locks capture.
// - Power failure sets flag 30.
// - Sweep completion sets flag 31.
// - Enabled set flag raises request, bit 32.
// - Capture keeps first locking error only.
// - Capture holds address and word number.
// - Capture marks sweep and channel references.
// - Capture bit 6 gives read or write.
// - Bits 4-6 encode the data source.
// - Capture held until locking flags cleared.
// - Reset leaves the capture register untouched.
// - Priority command bits force bad parity.
// - Interrupt-instruction page failure raises interrupt, not trap.
// - Bad memory word gives trap before interrupt.
// - Interrupt may lag flag by few instructions.
// - Storage bus supports a diagnostic cycle.
// - Diagnostic sends function word, returns controller word.
// - Command bits enable, disable, clear, set flags; level.
// - Memory timeout sets no-memory flag, locks capture.
`default_nettype none
module processor_error_capture
#(
   parameter int NOMEM_CYC = processor_error_pkg::NOMEM_CYCLES
)
(
   input wire logic clk_sys, // System clock, 40 MHz.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic cmd_valid, // Command request.
   input wire processor_error_pkg::cmd_type cmd, // Command code and operand word.
   output logic cmd_ready_ff, // Command can be taken.
   output logic rsp_valid_ff, // One-cycle pulse, answer valid.
   output processor_error_pkg::word_type rsp_data_ff, // Answer word.
   input wire processor_error_pkg::ref_info_type ref_info, // Current memory reference.
   input wire logic ref_start, // A memory reference begins.
   input wire logic ref_done, // The memory answered the reference.
   input wire logic mb_parity_bad, // Memory buffer received even parity.
   input wire logic addr_parity_err, // Controller saw even address parity.
   input wire logic sbus_err, // Controller reports an error.
   input wire logic cache_dir_bad, // Directory page number with even parity.
   input wire logic sweep_busy, // Cache sweep in progress.
   input wire logic sweep_done, // Cache sweep finished, one-cycle pulse.
   input wire logic power_fail_pin, // AC power failed, asynchronous level.
   input wire logic page_fail, // Pager reports a page failure.
   input wire logic in_intr_instr, // An interrupt instruction is executing.
   output logic [1:7] pi_req_ff, // Request on the assigned priority level.
   output logic cache_enable_ff, // Cache may be used.
   output processor_error_pkg::force_par_type force_par_ff, // Active parity forcing.
   output logic io_reset_ff, // One-cycle reset pulse for peripherals.
   output logic page_fail_trap_ff, // Take the page failure trap.
   output logic diag_req_ff, // Storage bus diagnostic request.
   output logic [4:0] diag_sel_ff, // Diagnostic controller select.
   output processor_error_pkg::word_type diag_word_ff, // Diagnostic function word.
   input wire logic diag_ack, // Controller took the function word.
   input wire logic diag_ret_valid, // Controller return word valid.
   input wire processor_error_pkg::word_type diag_ret // Controller return word.
);
   import processor_error_pkg::*;

   localparam int TW = $clog2(NOMEM_CYC + 1);
   if (NOMEM_CYC < 2)
   begin : g_chk
      $error("processor_error_capture timeout too short");
   end

   // ---------------------------------------------------------------------------
   // Command decode
   // ---------------------------------------------------------------------------
   wire cmd_take = cmd_valid && cmd_ready_ff;
   wire co_take = cmd_take && (cmd.op == CMD_COND_OUT);
   wire ci_take = cmd_take && (cmd.op == CMD_COND_IN);
   wire po_take = cmd_take && (cmd.op == CMD_PI_OUT);
   wire pi_take = cmd_take && (cmd.op == CMD_PI_IN);
   wire rc_take = cmd_take && (cmd.op == CMD_READ_CAPTURE);
   wire dg_take = cmd_take && (cmd.op == CMD_DIAG);
   wire flag_type co_sel = cmd.data[FLAG_FIRST:FLAG_LAST];
   wire flag_type sw_en = (co_take && cmd.data[CO_ENABLE]) ? co_sel : FLAGS_RST;
   wire flag_type sw_dis = (co_take && cmd.data[CO_DISABLE]) ? co_sel : FLAGS_RST;
   wire flag_type sw_clr = (co_take && cmd.data[CO_CLEAR]) ? co_sel : FLAGS_RST;
   wire flag_type sw_set = (co_take && cmd.data[CO_SET]) ? co_sel : FLAGS_RST;

   // ---------------------------------------------------------------------------
   // Power-fail synchroniser and no-memory timer
   // ---------------------------------------------------------------------------
   logic pwr_s1_ff;
   logic pwr_s2_ff;
   logic pwr_s3_ff;
   wire pwr_rise = pwr_s2_ff && !pwr_s3_ff;

   logic ref_busy_ff;
   logic [TW-1:0] ref_cnt_ff;
   ref_info_type ref_hold_ff;
   wire nomem_evt = ref_busy_ff && !ref_done && (ref_cnt_ff == TW'(NOMEM_CYC - 1));

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         pwr_s1_ff <= 1'b0;
         pwr_s2_ff <= 1'b0;
         pwr_s3_ff <= 1'b0;
         ref_busy_ff <= 1'b0;
         ref_cnt_ff <= '0;
         ref_hold_ff <= '0;
      end
      else
      begin
         pwr_s1_ff <= power_fail_pin;
         pwr_s2_ff <= pwr_s1_ff;
         pwr_s3_ff <= pwr_s2_ff;
         if (ref_start)
         begin
            ref_busy_ff <= 1'b1;
            ref_cnt_ff <= '0;
            ref_hold_ff <= ref_info;
         end
         else if (ref_done || nomem_evt)
            ref_busy_ff <= 1'b0;
         else if (ref_busy_ff)
            ref_cnt_ff <= ref_cnt_ff + TW'(1);
      end
   end

   // ---------------------------------------------------------------------------
   // Flags, enables and interrupt request
   // ---------------------------------------------------------------------------
   flag_type flags_ff;
   flag_type en_ff;
   logic [2:0] level_ff;
   logic irq_ff;
   flag_type hw_set;
   flag_type nxt_flags;
   flag_type nxt_en;

   always_comb
   begin
      hw_set = FLAGS_RST;
      hw_set[F_SBUS] = sbus_err;
      hw_set[F_NOMEM] = nomem_evt;
      hw_set[F_IOPF] = page_fail && in_intr_instr;
      hw_set[F_MBPAR] = mb_parity_bad;
      hw_set[F_CDIR] = cache_dir_bad;
      hw_set[F_APAR] = addr_parity_err;
      hw_set[F_PWR] = pwr_rise;
      hw_set[F_SWEEP] = sweep_done;
   end

   // A hardware event in the same cycle as a clear survives: set wins.
   assign nxt_flags = (flags_ff & ~sw_clr) | sw_set | hw_set;
   assign nxt_en = (en_ff & ~sw_dis) | sw_en;

   // The request follows the flags by one cycle, so a page failure trap raised by
   // the same bad word always reaches the pager one cycle ahead of the interrupt.
   wire irq_now = |(flags_ff & en_ff);
   wire lock_now = |(flags_ff & LOCK_MASK);
   wire lock_evt = nomem_evt || mb_parity_bad || addr_parity_err;

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         flags_ff <= FLAGS_RST;
         en_ff <= FLAGS_RST;
         level_ff <= LEVEL_NONE;
         irq_ff <= 1'b0;
         pi_req_ff <= '0;
         cache_enable_ff <= 1'b1;
         page_fail_trap_ff <= 1'b0;
         io_reset_ff <= 1'b0;
         force_par_ff <= '0;
      end
      else
      begin
         flags_ff <= nxt_flags;
         en_ff <= nxt_en;
         if (co_take)
            level_ff <= cmd.data[LVL_FIRST:LVL_LAST];
         irq_ff <= irq_now;
         for (int l = 1; l <= 7; l++)
            pi_req_ff[l] <= irq_now && (level_ff == 3'(l));
         cache_enable_ff <= !nxt_flags[F_CDIR];
         page_fail_trap_ff <= page_fail && !in_intr_instr;
         io_reset_ff <= co_take && cmd.data[CO_IO_RESET];
         if (po_take)
            force_par_ff <= cmd.data[FP_FIRST:FP_LAST];
      end
   end

   // ---------------------------------------------------------------------------
   // Error address capture
   // ---------------------------------------------------------------------------
   word_type era_ff;
   word_type cap_word;
   ref_info_type cap_src;

   assign cap_src = nomem_evt ? ref_hold_ff : ref_info;

   always_comb
   begin
      cap_word = '0;
      cap_word[CAP_WORD_FIRST:CAP_WORD_LAST] = cap_src.word_num;
      cap_word[CAP_SWEEP] = cap_src.sweep;
      cap_word[CAP_CHAN] = cap_src.channel;
      cap_word[CAP_SRC_FIRST:CAP_SRC_LAST] = cap_src.source;
      cap_word[CAP_WRITE] = cap_src.write;
      cap_word[CAP_ADDR_FIRST:CAP_ADDR_LAST] = cap_src.addr;
   end

   // No reset here, so the register can still be read after a master reset.
   always_ff @(posedge clk_sys)
   begin
      if (lock_evt && !lock_now)
         era_ff <= cap_word;
   end

   // ---------------------------------------------------------------------------
   // Status word, answers and diagnostic cycle
   // ---------------------------------------------------------------------------
   word_type status_word;
   word_type force_word;
   logic dg_busy;
   logic dg_done;
   word_type dg_ret;

   always_comb
   begin
      status_word = '0;
      status_word[EN_FIRST:EN_LAST] = en_ff;
      status_word[SWEEP_BUSY_BIT] = sweep_busy;
      status_word[FLAG_FIRST:FLAG_LAST] = flags_ff;
      status_word[IRQ_BIT] = irq_ff;
      status_word[LVL_FIRST:LVL_LAST] = level_ff;
      force_word = '0;
      force_word[FP_FIRST:FP_LAST] = force_par_ff;
   end

   storage_bus_diag #(.TIMEOUT_CYC(NOMEM_CYC)) u_diag
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .start(dg_take),
      .func_word(cmd.data),
      .busy_ff(dg_busy),
      .done_ff(dg_done),
      .ret_ff(dg_ret),
      .diag_req_ff(diag_req_ff),
      .diag_sel_ff(diag_sel_ff),
      .diag_word_ff(diag_word_ff),
      .diag_ack(diag_ack),
      .diag_ret_valid(diag_ret_valid),
      .diag_ret(diag_ret)
   );

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         rsp_valid_ff <= 1'b0;
         rsp_data_ff <= '0;
         cmd_ready_ff <= 1'b0;
      end
      else
      begin
         rsp_valid_ff <= (cmd_take && !dg_take) || dg_done;
         cmd_ready_ff <= !dg_take && !(dg_busy && !dg_done);
         if (ci_take)
            rsp_data_ff <= status_word;
         else if (pi_take)
            rsp_data_ff <= force_word;
         else if (rc_take)
            rsp_data_ff <= era_ff;
         else if (dg_done)
            rsp_data_ff <= dg_ret;
         else if (cmd_take)
            rsp_data_ff <= '0;
      end
   end

   // ---------------------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_first_lock;
      lock_evt && !lock_now;
   endsequence
   sequence s_bad_mem_word;
      page_fail && !in_intr_instr && mb_parity_bad && en_ff[F_MBPAR] && !cmd_valid
         && level_ff != LEVEL_NONE;
   endsequence

   mb_parity_flag_a: assert property (mb_parity_bad |=> flags_ff[F_MBPAR])
      else $error("memory buffer parity flag not set");
   cache_off_a: assert property (cache_enable_ff == !flags_ff[F_CDIR])
      else $error("cache enable disagrees with directory flag");
   addr_parity_flag_a: assert property (addr_parity_err |=> flags_ff[F_APAR])
      else $error("address parity flag not set");
   power_flag_a: assert property (pwr_rise |=> flags_ff[F_PWR])
      else $error("power fail flag not set");
   sweep_flag_a: assert property (sweep_done |=> flags_ff[F_SWEEP])
      else $error("sweep done flag not set");
   irq_level_a: assert property (irq_now && level_ff != LEVEL_NONE |=> pi_req_ff != '0)
      else $error("enabled flag did not request");
   capture_first_a: assert property (s_first_lock |=> era_ff == $past(cap_word))
      else $error("first locking error not captured");
   capture_hold_a: assert property (lock_now |=> $stable(era_ff))
      else $error("capture changed while locked");
   intr_page_fail_a: assert property (page_fail && in_intr_instr |=> !page_fail_trap_ff && flags_ff[F_IOPF])
      else $error("page failure in interrupt instruction trapped");
   trap_first_a: assert property (s_bad_mem_word |=> page_fail_trap_ff ##1 (pi_req_ff != '0))
      else $error("trap and interrupt out of order");
   force_readback_a: assert property (po_take |=> force_par_ff == $past(cmd.data[FP_FIRST:FP_LAST]))
      else $error("parity forcing not taken");
   nomem_flag_a: assert property (nomem_evt |=> flags_ff[F_NOMEM] && !ref_busy_ff)
      else $error("no memory flag not set");
endmodule : processor_error_capture
`default_nettype wire

// ==== verif/storage_ctrl_model.sv ====
// Behavioural storage controller that answers the diagnostic bus cycle.
`default_nettype none
module storage_ctrl_model
(
   input wire logic clk_sys, // System clock.
   input wire logic rst, // Reset, active high.
   input wire logic diag_req, // Diagnostic request.
   input wire processor_error_pkg::word_type diag_word, // Function word.
   input wire logic [3:0] dly, // Answer delay in cycles.
   output logic diag_ack, // Function word taken.
   output logic diag_ret_valid, // Return word valid.
   output processor_error_pkg::word_type diag_ret // Return word.
);
   timeunit 1ns;
   timeprecision 1ps;
   import processor_error_pkg::*;
   word_type w;
   // The answer is the inverted function word, so every bit is seen in both states.
   initial
   begin
      diag_ack = 1'b0;
      diag_ret_valid = 1'b0;
      diag_ret = '0;
      forever
      begin
         @(posedge clk_sys);
         if (diag_req === 1'b1 && rst === 1'b0)
         begin
            w = diag_word;
            repeat (dly) @(posedge clk_sys);
            diag_ack <= 1'b1;
            @(posedge clk_sys);
            diag_ack <= 1'b0;
            repeat (dly) @(posedge clk_sys);
            diag_ret <= ~w;
            diag_ret_valid <= 1'b1;
            @(posedge clk_sys);
            diag_ret_valid <= 1'b0;
         end
         // Idle return lines toggle so a stale word never passes for an answer.
         diag_ret <= ~diag_ret;
      end
   end
endmodule : storage_ctrl_model
`default_nettype wire

// ==== verif/tb_processor_error_capture.sv ====
// Self-checking testbench of the processor error capture block.
`default_nettype none
module tb_processor_error_capture;
   timeunit 1ns;
   timeprecision 1ps;
   import processor_error_pkg::*;
   logic clk_sys = 1'b0, rst = 1'b1, cmd_valid = 1'b0, ref_start = 1'b0, pwr = 1'b0;
   logic buf_par = 1'b0, cdir = 1'b0, apar = 1'b0, swd = 1'b0, pf = 1'b0, intr = 1'b0;
   logic cmd_ready_ff, rsp_valid_ff, cache_enable_ff, io_reset_ff, page_fail_trap_ff;
   logic diag_req_ff, diag_ack, diag_ret_valid;
   logic [1:7] pi_req_ff, e;
   logic [4:0] diag_sel_ff, sel_seen;
   logic [3:0] dly = 4'h0;
   cmd_type cmd = '0;
   word_type rsp_data_ff, diag_word_ff, diag_ret, rsp, w;
   ref_info_type ref_info = '0, first, r3;
   force_par_type force_par_ff;
   logic [2:0] lvl;
   int fail_count = 0, cmp_count = 0, cyc = 0;
   always #12.5 clk_sys = ~clk_sys;
   processor_error_capture #(.NOMEM_CYC(20)) u_processor_error_capture (.clk_sys, .rst,
      .cmd_valid, .cmd, .cmd_ready_ff, .rsp_valid_ff, .rsp_data_ff, .ref_info, .ref_start,
      .ref_done(1'b0), .mb_parity_bad(buf_par), .addr_parity_err(apar), .sbus_err(1'b0),
      .cache_dir_bad(cdir), .sweep_busy(1'b0), .sweep_done(swd), .power_fail_pin(pwr),
      .page_fail(pf), .in_intr_instr(intr), .pi_req_ff, .cache_enable_ff, .force_par_ff,
      .io_reset_ff, .page_fail_trap_ff, .diag_req_ff, .diag_sel_ff, .diag_word_ff,
      .diag_ack, .diag_ret_valid, .diag_ret);
   storage_ctrl_model u_storage_ctrl_model (.clk_sys, .rst, .diag_req(diag_req_ff),
      .diag_word(diag_word_ff), .dly, .diag_ack, .diag_ret_valid, .diag_ret);
   always @(posedge clk_sys)
   begin
      if (diag_req_ff === 1'b1)
         sel_seen <= diag_sel_ff;
      cyc++;
      if (cyc == 30000)
      begin
         fail_count++;
         conclude();
      end
   end
   // ---------------------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------------------
   task automatic chk(input string nm, input word_type ex, input word_type got);
      cmp_count++;
      if (got !== ex)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude
   task automatic run(input cmd_op_type op, input word_type d);
      int n;
      n = 0;
      cmd_valid <= 1'b1;
      cmd <= '{op, d};
      do @(posedge clk_sys); while (cmd_ready_ff !== 1'b1);
      cmd_valid <= 1'b0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (rsp_valid_ff !== 1'b1 && n < 300);
      rsp = rsp_data_ff;
   endtask : run
   function automatic word_type co(int ctl, flag_type f, logic [2:0] l);
      co = '0;
      co[ctl] = 1'b1;
      co[24:31] = f;
      co[33:35] = l;
   endfunction : co
   function automatic word_type capw(ref_info_type r);
      return {r.word_num, r.sweep, r.channel, r.source, r.write, 7'h0, r.addr};
   endfunction : capw
   task automatic pulse(int k);
      case (k)
         0: buf_par <= 1'b1;
         1: cdir <= 1'b1;
         2: apar <= 1'b1;
         default: swd <= 1'b1;
      endcase
      @(posedge clk_sys);
      {buf_par, cdir, apar, swd} <= '0;
      repeat (2) @(posedge clk_sys);
   endtask : pulse
   task automatic flags(flag_type f);
      run(CMD_COND_IN, '0);
      chk("flags", {28'h0, f}, {28'h0, rsp[24:31]});
   endtask : flags
   task automatic read_cap(ref_info_type r);
      run(CMD_READ_CAPTURE, '0);
      chk("capture", capw(r), rsp);
   endtask : read_cap
   // ---------------------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------------------
   initial
   begin
      void'($urandom(32'h5a90));
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk("cache_en", 36'h1, {35'h0, cache_enable_ff});
      for (int k = 0; k < 4; k++)
      begin
         pulse(k);
         flags(8'h10 >> (k + (k == 3 ? 1 : 0)));
         if (k == 1)
            chk("cache_off", 36'h0, {35'h0, cache_enable_ff});
         run(CMD_COND_OUT, co(CO_CLEAR, 8'hff, 3'h0));
      end
      chk("cache_on", 36'h1, {35'h0, cache_enable_ff});
      run(CMD_COND_OUT, co(CO_IO_RESET, 8'h00, 3'h0));
      chk("io_reset", 36'h1, {35'h0, io_reset_ff});
      pwr <= 1'b1;
      repeat (6) @(posedge clk_sys);
      flags(8'h02);
      pwr <= 1'b0;
      intr <= 1'b1;
      pf <= 1'b1;
      @(posedge clk_sys);
      pf <= 1'b0;
      @(posedge clk_sys);
      #1 chk("no_trap", 36'h0, {35'h0, page_fail_trap_ff});
      flags(8'h22);
      run(CMD_COND_OUT, co(CO_CLEAR, 8'hff, 3'h0));
      for (int j = 0; j < 8; j++)
      begin
         lvl = 3'($urandom_range(1, 7));
         e = '0;
         e[lvl] = 1'b1;
         run(CMD_COND_OUT, co(CO_ENABLE, 8'h80 >> j, lvl));
         run(CMD_COND_OUT, co(CO_SET, 8'h80 >> j, lvl));
         @(posedge clk_sys);
         chk("pi_req", {29'h0, e}, {29'h0, pi_req_ff});
         run(CMD_COND_IN, '0);
         chk("status", {6'h0, 8'h80 >> j, 10'h0, 8'h80 >> j, 1'b1, lvl}, rsp);
         run(CMD_COND_OUT, co(CO_DISABLE, 8'h80 >> j, lvl));
         @(posedge clk_sys);
         chk("pi_off", 36'h0, {29'h0, pi_req_ff});
         run(CMD_COND_OUT, co(CO_CLEAR, 8'hff, lvl));
      end
      first = ref_info_type'({$urandom, $urandom});
      r3 = ref_info_type'({$urandom, $urandom});
      ref_info <= first;
      pulse(0);
      ref_info <= r3;
      pulse(2);
      read_cap(first);
      run(CMD_COND_OUT, co(CO_CLEAR, 8'h54, 3'h0));
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      read_cap(first);
      pulse(2);
      read_cap(r3);
      run(CMD_COND_OUT, co(CO_CLEAR, 8'h54, 3'h0));
      ref_info <= first;
      ref_start <= 1'b1;
      @(posedge clk_sys);
      ref_start <= 1'b0;
      ref_info <= r3;
      repeat (30) @(posedge clk_sys);
      flags(8'h40);
      read_cap(first);
      for (int i = 0; i < 4; i++)
      begin
         w = word_type'({$urandom, $urandom});
         run(CMD_PI_OUT, w);
         run(CMD_PI_IN, '0);
         chk("force_rd", {33'h0, w[18:20]}, {33'h0, rsp[18:20]});
         chk("force", {33'h0, w[18:20]}, {33'h0, force_par_ff});
         dly <= 4'(i * 3);
         run(CMD_DIAG, w);
         chk("diag_ret", ~w, rsp);
         chk("diag_sel", {31'h0, w[0:4]}, {31'h0, sel_seen});
      end
      conclude();
   end
endmodule : tb_processor_error_capture
`default_nettype wire
